// ### fcs_flash_model.sv
`timescale 1ns/1ns
module fcs_flash_model #(
  parameter logic [15:0] MFR_CODE    = 16'h00a1, // Arbitrary value
  parameter logic [15:0] DEV_CODE    = 16'h00b2, // Arbitrary value
  parameter logic [3:0]  PROT_SECT   = 4'h3,
  parameter logic [3:0]  SUSP_SECT   = 4'h5,
  parameter logic [7:0]  CMD_QUERY   = 8'h98,
  parameter logic [7:0]  CMD_AUTOSEL = 8'h90,
  parameter logic [7:0]  CMD_RESET   = 8'hf0
) (
  // Bus pins
  input  wire logic [19:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n,
  output logic      [15:0] flash_dq_in,
  // Mode and fault injection
  input  wire logic        byte_mode,
  input  wire logic        supply_low,
  input  wire logic        timeout_inject,
  input  wire logic        suspend_inject
);
  // 0 array, 1-2 unlocked, 3 autoselect, 4 query, 5 failed operation, 6 erase suspended
  int unsigned st = 0;
  logic        armed = 1'b0;
  logic [19:0] lat_a;
  logic [15:0] qry [0:12] = '{16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0030, 16'h0000,
    16'h0002, 16'h0001, 16'h0001, 16'h0004, 16'h0000, 16'h0000, 16'h0000};

  function automatic logic [15:0] rd(input logic [19:0] a);
    logic [7:0] po;
    po = byte_mode ? 8'h04 : 8'h02;
    if (st == 3 && a[7:0] == 8'h00) return MFR_CODE;
    if (st == 3 && a[7:0] == 8'h01) return DEV_CODE;
    if (st == 3 && a[7:0] == po) return {15'h0, a[19:16] == PROT_SECT};
    if (st == 4 && a[7:0] >= 8'h40 && a[7:0] <= 8'h4c) return qry[a[7:0] - 8'h40];
    if (st == 5) return 16'h0020;
    // Status word value is arbitrary, timeout bit kept clear
    if (st == 6 && a[19:16] == SUSP_SECT) return 16'h0044;
    return a[15:0] ^ 16'hc3a5;
  endfunction

  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    if (d[7:0] == CMD_RESET) st = 0;
    else if (st == 0 && a[11:0] == 12'h555 && d[7:0] == 8'haa) st = 1;
    else if (st == 0 && a[7:0] == 8'h55 && d[7:0] == CMD_QUERY) st = 4;
    else if (st == 1 && a[11:0] == 12'h2aa && d[7:0] == 8'h55) st = 2;
    else if (st == 2 && a[11:0] == 12'h555 && d[7:0] == CMD_AUTOSEL) st = 3;
    else if (st < 3) st = 0;
  endtask

  // Strobes already low at power-up never arm a write
  always @(negedge flash_we_n, negedge flash_ce_n, posedge flash_we_n, posedge flash_ce_n) begin
    if (!flash_we_n && !flash_ce_n) begin
      lat_a = flash_addr;
      armed = flash_oe_n && !supply_low;
    end else if (armed) begin
      armed = 1'b0;
      wr(lat_a, flash_dq_out);
    end
  end

  always @(posedge timeout_inject) st = 5;
  always @(posedge suspend_inject) st = 6;
  always @(posedge supply_low) st = 0;

  // Undriven bus shows a changing pattern, not the last value
  initial flash_dq_in = 16'h5555;
  always @(flash_ce_n, flash_oe_n, flash_addr, st)
    flash_dq_in = (!flash_ce_n && !flash_oe_n) ? rd(flash_addr) : ~flash_dq_in;
endmodule

// ### fcs_host.sv
`timescale 1ns/1ns
// Summary of operation
// (RULE1) Write needs chip and write low, output high
// (RULE2) Keep write strobe high through power-up
// (RULE3) Device reads array after power-up, no command
// (RULE4) Bad or misordered writes drop device to array
// (RULE5) Address before strobe falls, data held past rise
// (RULE6) Array reads need no command after power-up
// (RULE7) Suspended-sector reads give status, others array
// (RULE8) Reset command works at any address
// (RULE9) Reset aborts erase setup, ignored once erasing
// (RULE10) Reset aborts program setup, ignored once programming
// (RULE11) Reset aborts autoselect entry, exits autoselect mode
// (RULE12) Timeout flag seen: host writes reset command
// (RULE13) Autoselect: two unlocks then command, reads free
// (RULE14) Autoselect offsets zero, one give identity codes
// (RULE15) Sector plus 02h or 04h gives protection
// (RULE16) Supply lockout: no writes accepted
// (RULE17) Query words 40h-42h spell extended table tag
// (RULE18) Query 43h, 44h give version characters
// (RULE19) Query 45h reads zero: unlock required
// (RULE20) Query 46h reads two: suspend reads, programs
// (RULE21) Query 47h-49h give protection details
// (RULE22) Query 4Ah-4Ch read zero: features absent
// (RULE23) Unlock addresses and command codes are parameters
module fcs_host #(
  parameter int              AW           = 20,
  parameter int              DW           = 16,
  parameter logic [AW-1:0]   UNLOCK1_ADDR = 20'h00555,
  parameter logic [AW-1:0]   UNLOCK2_ADDR = 20'h002aa,
  parameter logic [7:0]      UNLOCK1_DATA = 8'haa,
  parameter logic [7:0]      UNLOCK2_DATA = 8'h55,
  parameter logic [7:0]      CMD_AUTOSEL  = 8'h90,
  parameter logic [7:0]      CMD_RESET    = 8'hf0
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          arst_n,
  // User command port
  input  wire logic          cmd_valid,
  input  wire logic [2:0]    cmd_op,
  input  wire logic [AW-1:0] cmd_addr,
  input  wire logic [DW-1:0] cmd_data,
  input  wire logic          byte_mode,
  output logic               cmd_ready,
  output logic               rsp_valid,
  output logic [DW-1:0]      rsp_data,
  output logic               rsp_timeout,
  // Flash pins
  output logic [AW-1:0]      flash_addr,
  output logic [DW-1:0]      flash_dq_out,
  output logic               flash_dq_oe_n,
  input  wire logic [DW-1:0] flash_dq_in,
  output logic               flash_ce_n,
  output logic               flash_we_n,
  output logic               flash_oe_n,
  input  wire logic          supply_low
);
  localparam int         RD_CYC_CHK = fcs_pkg::RD_CYC;
  localparam logic [3:0] CNT_ZERO_L = fcs_pkg::CNT_ZERO;

  initial begin
    if (AW < 9 || DW < 8 || RD_CYC_CHK > 15) $error("fcs_host: unsupported parameters");
  end

  // Pin inputs pass two flops before use
  logic [DW-1:0] dq_m, dq_s;
  logic          low_m, low_s;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dq_m  <= '0;
      dq_s  <= '0;
      low_m <= 1'b1;
      low_s <= 1'b1;
    end else begin
      dq_m  <= flash_dq_in;
      dq_s  <= dq_m;
      low_m <= supply_low;
      low_s <= low_m;
    end
  end

  fcs_pkg::fcs_state_e state, next_state;
  fcs_pkg::fcs_op_e    op, next_op;
  logic [1:0]          step, next_step;
  logic [3:0]          cnt, next_cnt;
  logic [AW-1:0]       addr, next_addr;
  logic [DW-1:0]       data, next_data;
  logic                next_cmd_ready, next_rsp_valid, next_rsp_timeout;
  logic [DW-1:0]       next_rsp_data;
  logic [AW-1:0]       next_flash_addr;
  logic [DW-1:0]       next_flash_dq_out;
  logic                next_flash_dq_oe_n, next_flash_ce_n;
  logic                next_flash_we_n, next_flash_oe_n;
  logic [AW-1:0]       cyc_addr;
  logic [DW-1:0]       cyc_data;
  logic [1:0]          last_step;
  logic                is_write;

  // Bus cycle contents for each step of a sequence
  always_comb begin
    cyc_addr  = addr;
    cyc_data  = data;
    last_step = 2'h0;
    unique case (op)
      fcs_pkg::FCS_OP_AUTOSEL: begin
        last_step = 2'h2; // RULE13
        unique case (step)
          2'h0: begin
            cyc_addr = UNLOCK1_ADDR; // RULE23
            cyc_data = DW'(UNLOCK1_DATA);
          end
          2'h1: begin
            cyc_addr = UNLOCK2_ADDR;
            cyc_data = DW'(UNLOCK2_DATA);
          end
          default: begin
            cyc_addr = UNLOCK1_ADDR;
            cyc_data = DW'(CMD_AUTOSEL);
          end
        endcase
      end
      // Address left as given; the device ignores it
      fcs_pkg::FCS_OP_RESET: cyc_data = DW'(CMD_RESET); // RULE8 RULE11
      default: ;
    endcase
  end

  always_comb begin
    is_write = (cmd_op == fcs_pkg::FCS_OP_WRITE) || (cmd_op == fcs_pkg::FCS_OP_RESET) ||
               (cmd_op == fcs_pkg::FCS_OP_AUTOSEL);
    next_state         = state;
    next_op            = op;
    next_step          = step;
    next_cnt           = cnt;
    next_addr          = addr;
    next_data          = data;
    next_cmd_ready     = 1'b0;
    next_rsp_valid     = 1'b0;
    next_rsp_data      = rsp_data;
    next_rsp_timeout   = rsp_timeout;
    next_flash_addr    = flash_addr;
    next_flash_dq_out  = flash_dq_out;
    next_flash_dq_oe_n = 1'b1;
    next_flash_ce_n    = 1'b1;
    next_flash_we_n    = 1'b1;
    next_flash_oe_n    = 1'b1;
    unique case (state)
      // Strobes idle high until supply settles
      fcs_pkg::FCS_PWRUP: begin
        next_cnt = cnt + 4'h1; // RULE2
        if (cnt == 4'(fcs_pkg::PWRUP_CYC - 1)) begin
          next_state     = fcs_pkg::FCS_IDLE;
          next_cmd_ready = !low_s;
        end
      end
      fcs_pkg::FCS_IDLE: begin
        next_cmd_ready = !low_s;
        if (cmd_valid && cmd_ready && !(is_write && low_s)) begin // RULE16
          next_cmd_ready   = 1'b0;
          next_op          = fcs_pkg::fcs_op_e'(cmd_op);
          next_addr        = cmd_addr;
          next_data        = cmd_data;
          next_step        = 2'h0;
          next_rsp_timeout = 1'b0;
          if (cmd_op == fcs_pkg::FCS_OP_PROT) begin
            next_addr[7:0] = byte_mode ? fcs_pkg::PROT_OFS_BYTE
                                       : fcs_pkg::PROT_OFS_WORD; // RULE15
          end
          next_state = is_write ? fcs_pkg::FCS_WSETUP : fcs_pkg::FCS_RSETUP;
        end
      end
      // Address settles before the write strobe falls
      fcs_pkg::FCS_WSETUP: begin
        next_flash_addr    = cyc_addr; // RULE5
        next_flash_dq_out  = cyc_data;
        next_flash_dq_oe_n = 1'b0;
        next_flash_ce_n    = 1'b0;
        next_cnt           = CNT_ZERO_L;
        // Lockout stalls the sequence with write strobe high, chip enable low
        if (!low_s) next_state = fcs_pkg::FCS_WLOW; // RULE16
      end
      fcs_pkg::FCS_WLOW: begin
        next_flash_dq_oe_n = 1'b0;
        next_flash_ce_n    = 1'b0;
        next_flash_we_n    = 1'b0; // RULE1
        next_cnt           = cnt + 4'h1;
        // Strobe stays low for the whole pulse; it rises in the hold state
        if (cnt == 4'(fcs_pkg::WP_CYC - 1)) begin
          next_state = fcs_pkg::FCS_WHOLD;
        end
      end
      // Data held one cycle past the write strobe rise
      fcs_pkg::FCS_WHOLD: begin
        // Chip enable and data stay on so the write strobe rise latches
        next_flash_dq_oe_n = 1'b0;
        next_flash_ce_n    = 1'b0; // RULE1
        if (step != last_step) begin
          next_step  = step + 2'h1;
          next_state = fcs_pkg::FCS_WSETUP;
        end else begin
          next_rsp_valid = 1'b1;
          next_state     = fcs_pkg::FCS_IDLE;
        end
      end
      fcs_pkg::FCS_RSETUP: begin
        next_flash_addr = addr;
        next_flash_ce_n = 1'b0;
        next_flash_oe_n = 1'b0;
        next_cnt        = CNT_ZERO_L;
        next_state      = fcs_pkg::FCS_RWAIT;
      end
      fcs_pkg::FCS_RWAIT: begin
        next_flash_ce_n = 1'b0;
        next_flash_oe_n = 1'b0;
        next_cnt        = cnt + 4'h1;
        if (cnt == 4'(fcs_pkg::RD_CYC - 1)) begin
          next_flash_ce_n = 1'b1;
          next_flash_oe_n = 1'b1;
          next_rsp_data   = dq_s;
          if (op == fcs_pkg::FCS_OP_POLL && dq_s[fcs_pkg::TIMEOUT_BIT]) begin
            // Timed-out operation: a reset is the only way back
            next_rsp_timeout = 1'b1; // RULE12
            next_op          = fcs_pkg::FCS_OP_RESET;
            next_step        = 2'h0;
            next_state       = fcs_pkg::FCS_WSETUP;
          end else begin
            next_rsp_valid = 1'b1;
            next_state     = fcs_pkg::FCS_IDLE;
          end
        end
      end
    endcase
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state         <= fcs_pkg::FCS_PWRUP;
      op            <= fcs_pkg::FCS_OP_READ;
      step          <= 2'h0;
      cnt           <= 4'h0;
      addr          <= '0;
      data          <= '0;
      cmd_ready     <= 1'b0;
      rsp_valid     <= 1'b0;
      rsp_data      <= '0;
      rsp_timeout   <= 1'b0;
      flash_addr    <= '0;
      flash_dq_out  <= '0;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
    end else begin
      state         <= next_state;
      op            <= next_op;
      step          <= next_step;
      cnt           <= next_cnt;
      addr          <= next_addr;
      data          <= next_data;
      cmd_ready     <= next_cmd_ready;
      rsp_valid     <= next_rsp_valid;
      rsp_data      <= next_rsp_data;
      rsp_timeout   <= next_rsp_timeout;
      flash_addr    <= next_flash_addr;
      flash_dq_out  <= next_flash_dq_out;
      flash_dq_oe_n <= next_flash_dq_oe_n;
      flash_ce_n    <= next_flash_ce_n;
      flash_we_n    <= next_flash_we_n;
      flash_oe_n    <= next_flash_oe_n;
    end
  end

  chk_write_strobe_qual: assert property (@(posedge mclk) disable iff (!arst_n)
    !flash_we_n |-> !flash_ce_n && flash_oe_n && !flash_dq_oe_n) // RULE1
    else $error("write strobe low without qualifying strobes");
  chk_read_no_drive: assert property (@(posedge mclk) disable iff (!arst_n)
    !flash_oe_n |-> flash_dq_oe_n && flash_we_n) // RULE1
    else $error("data driven during a read");
  chk_pwrup_we_high: assert property (@(posedge mclk) disable iff (!arst_n)
    state == fcs_pkg::FCS_PWRUP |-> flash_we_n && flash_ce_n) // RULE2
    else $error("strobe active during power-up wait");
  chk_lockout_no_write: assert property (@(posedge mclk) disable iff (!arst_n)
    $fell(flash_we_n) |-> !$past(low_s, 2)) // RULE16
    else $error("write started under supply lockout");
  chk_addr_stable_we: assert property (@(posedge mclk) disable iff (!arst_n)
    !flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_out)) // RULE5
    else $error("address or data moved while write strobe low");
  chk_data_past_rise: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(flash_we_n) |-> !flash_ce_n && $stable(flash_dq_out) && !flash_dq_oe_n) // RULE5
    else $error("data not held at write strobe rise");
  chk_reset_code: assert property (@(posedge mclk) disable iff (!arst_n)
    !flash_we_n && op == fcs_pkg::FCS_OP_RESET |-> flash_dq_out == DW'(CMD_RESET)) // RULE8
    else $error("reset command carries wrong code");
  chk_timeout_reset: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(rsp_timeout) |-> ##[1:4] (!flash_we_n && flash_dq_out == DW'(CMD_RESET))) // RULE12
    else $error("no reset written after timeout flag");
  chk_autosel_third: assert property (@(posedge mclk) disable iff (!arst_n)
    !flash_we_n && op == fcs_pkg::FCS_OP_AUTOSEL && step == 2'h2
    |-> flash_addr == UNLOCK1_ADDR && flash_dq_out == DW'(CMD_AUTOSEL)) // RULE13
    else $error("autoselect command cycle wrong");
  chk_prot_offset: assert property (@(posedge mclk) disable iff (!arst_n)
    !flash_oe_n && op == fcs_pkg::FCS_OP_PROT
    |-> flash_addr[7:0] == fcs_pkg::PROT_OFS_WORD || flash_addr[7:0] == fcs_pkg::PROT_OFS_BYTE) // RULE15
    else $error("protection query offset wrong");

  cov_autosel: cover property (@(posedge mclk) disable iff (!arst_n)
    op == fcs_pkg::FCS_OP_AUTOSEL && rsp_valid);
  cov_read: cover property (@(posedge mclk) disable iff (!arst_n)
    op == fcs_pkg::FCS_OP_READ && rsp_valid);
  cov_timeout: cover property (@(posedge mclk) disable iff (!arst_n)
    rsp_timeout && rsp_valid);
  cov_lock_stall: cover property (@(posedge mclk) disable iff (!arst_n)
    state == fcs_pkg::FCS_WSETUP && low_s);
endmodule

// ### fcs_pkg.sv
package fcs_pkg;
  // Bus timing, the controller runs on a 100 ns clock
  localparam int CLK_NS       = 100;
  localparam int T_ACC_NS     = 70;
  localparam int T_WP_NS      = 35;
  localparam int T_PWRUP_NS   = 1000;
  localparam int SYNC_STAGES  = 2;
  localparam int ACC_CYC      = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC       = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PWRUP_CYC    = (T_PWRUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC       = ACC_CYC + SYNC_STAGES;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  // Status bit that flags an exceeded embedded-operation time
  localparam int TIMEOUT_BIT  = 5;
  // Protection query offsets within a sector
  localparam logic [7:0] PROT_OFS_WORD = 8'h02;
  localparam logic [7:0] PROT_OFS_BYTE = 8'h04;

  typedef enum logic [2:0] {
    FCS_OP_READ,
    FCS_OP_WRITE,
    FCS_OP_RESET,
    FCS_OP_AUTOSEL,
    FCS_OP_PROT,
    FCS_OP_POLL
  } fcs_op_e;

  typedef enum {
    FCS_PWRUP,
    FCS_IDLE,
    FCS_WSETUP,
    FCS_WLOW,
    FCS_WHOLD,
    FCS_RSETUP,
    FCS_RWAIT
  } fcs_state_e;
endpackage

// ### tb_top.sv
`timescale 1ns/1ns
module tb_top;
  localparam logic [15:0] MFR = 16'h00a1;
  localparam logic [15:0] DEV = 16'h00b2;
  logic        mclk = 1'b0, arst_n = 1'b0, cmd_valid = 1'b0, byte_mode = 1'b0;
  logic        supply_low = 1'b0, timeout_inject = 1'b0, suspend_inject = 1'b0;
  logic [2:0]  cmd_op = 3'h0;
  logic [19:0] cmd_addr = 20'h0, faddr, we_addr;
  logic [15:0] cmd_data = 16'h0, rsp_data, dq_out, dq_in;
  logic        cmd_ready, rsp_valid, rsp_timeout, dq_oe_n, ce_n, we_n, oe_n;
  int          err_total = 0;
  int          tests_run = 0;
  logic [15:0] qexp [0:12] = '{16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0030, 16'h0000,
    16'h0002, 16'h0001, 16'h0001, 16'h0004, 16'h0000, 16'h0000, 16'h0000};

  initial forever #50 mclk = ~mclk;

  fcs_host dut (.mclk(mclk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .byte_mode(byte_mode), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_timeout(rsp_timeout),
    .flash_addr(faddr), .flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_in),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .supply_low(supply_low));

  fcs_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) flash (.flash_addr(faddr),
    .flash_dq_out(dq_out), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
    .flash_dq_in(dq_in), .byte_mode(byte_mode), .supply_low(supply_low),
    .timeout_inject(timeout_inject), .suspend_inject(suspend_inject));

  task automatic tally_and_finish();
    if (err_total == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [15:0] arr(input logic [19:0] a);
    return a[15:0] ^ 16'hc3a5;
  endfunction

  task automatic req(input fcs_pkg::fcs_op_e op, input logic [19:0] a, input logic [15:0] d);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 200);
    cmd_valid <= 1'b0;
    do begin
      @(posedge mclk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 400);
    if (rsp_valid !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
  endtask

  task automatic rdchk(input string what, input logic [19:0] a, input logic [15:0] exp);
    req(fcs_pkg::FCS_OP_READ, a, 16'h0);
    chk(what, rsp_data, exp);
  endtask

  // Every falling write strobe must be a legal, powered write cycle
  always @(negedge we_n) begin
    we_addr = faddr;
    chk("write strobes", {12'h0, ce_n, oe_n, dq_oe_n, supply_low}, 16'h0004);
  end
  always @(posedge we_n)
    if (arst_n) chk("write address hold", faddr[15:0], we_addr[15:0]);

  task automatic s_reset();
    chk("strobes in reset", {12'h0, ce_n, we_n, oe_n, dq_oe_n}, 16'h000f);
    arst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    chk("ready in power-up", {15'h0, cmd_ready}, 16'h0);
    rdchk("array at power-up", 20'h00000, arr(20'h00000));
    rdchk("array top", 20'hfffff, arr(20'hfffff));
  endtask

  task automatic s_autosel();
    req(fcs_pkg::FCS_OP_AUTOSEL, 20'h0, 16'h0);
    rdchk("maker code", 20'h54300, MFR);
    rdchk("part code", 20'h7ab01, DEV);
    rdchk("maker code again", 20'h00000, MFR);
    req(fcs_pkg::FCS_OP_PROT, 20'h30077, 16'h0);
    chk("protected word", rsp_data, 16'h0001);
    byte_mode <= 1'b1;
    req(fcs_pkg::FCS_OP_PROT, 20'h40000, 16'h0);
    chk("unprotected byte", rsp_data, 16'h0000);
    req(fcs_pkg::FCS_OP_PROT, 20'h30000, 16'h0);
    chk("protected byte", rsp_data, 16'h0001);
    byte_mode <= 1'b0;
    req(fcs_pkg::FCS_OP_RESET, 20'habcde, 16'h0);
    rdchk("array after exit", 20'h00000, arr(20'h00000));
  endtask

  task automatic s_badseq();
    logic [19:0] a2 [0:1] = '{20'h002aa, 20'h00123};
    for (int i = 0; i < 2; i++) begin
      req(fcs_pkg::FCS_OP_WRITE, 20'h00555, 16'h00aa);
      req(fcs_pkg::FCS_OP_WRITE, a2[i], 16'h0055);
      if (i == 0) req(fcs_pkg::FCS_OP_RESET, 20'h00000, 16'h0);
      req(fcs_pkg::FCS_OP_WRITE, 20'h00555, 16'h0090);
      rdchk("array after abort", 20'h00001, arr(20'h00001));
    end
  endtask

  task automatic s_query();
    req(fcs_pkg::FCS_OP_WRITE, 20'h00055, 16'h0098);
    for (int i = 0; i < 13; i++)
      rdchk("query word", 20'h00040 + 20'(i), qexp[i]);
    req(fcs_pkg::FCS_OP_RESET, 20'h00000, 16'h0);
  endtask

  task automatic s_poll();
    // Array word at this address has the timeout bit clear
    req(fcs_pkg::FCS_OP_POLL, 20'h00120, 16'h0);
    chk("poll clean flag", {15'h0, rsp_timeout}, 16'h0);
    chk("poll clean data", rsp_data, arr(20'h00120));
    timeout_inject <= 1'b1;
    req(fcs_pkg::FCS_OP_POLL, 20'h00200, 16'h0);
    chk("poll timeout flag", {15'h0, rsp_timeout}, 16'h0001);
    timeout_inject <= 1'b0;
    rdchk("array after recovery", 20'h00200, arr(20'h00200));
    chk("timeout flag cleared", {15'h0, rsp_timeout}, 16'h0);
    suspend_inject <= 1'b1;
    rdchk("suspended sector", 20'h51234, 16'h0044);
    rdchk("other sector", 20'h61234, arr(20'h61234));
    suspend_inject <= 1'b0;
    req(fcs_pkg::FCS_OP_RESET, 20'h00000, 16'h0);
    rdchk("array after suspend", 20'h51234, arr(20'h51234));
  endtask

  task automatic s_lockout();
    req(fcs_pkg::FCS_OP_AUTOSEL, 20'h0, 16'h0);
    supply_low <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("ready in lockout", {15'h0, cmd_ready}, 16'h0);
    supply_low <= 1'b0;
    rdchk("array after lockout", 20'h00000, arr(20'h00000));
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    s_reset();
    s_autosel();
    s_badseq();
    s_query();
    s_poll();
    s_lockout();
    tally_and_finish();
  end
endmodule
